// file: verification/dds_link_assertions.sv
// link checker: timing of the host's serial and load lines
module dds_link_assertions #(
	parameter int HALF = 2
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic frame_n,
	input wire logic output_load_strobe_n
);
	// ==========
	// run lengths; gap starts full so a first frame may come early
	logic [9:0] lo_r, hi_r, st_r;
	always_ff @(posedge sys_clk) begin
		lo_r <= (rst || frame_n) ? 10'h000 : lo_r + 10'h001;
		hi_r <= rst ? 10'h3ff : !frame_n ? 10'h000
			: hi_r + 10'(hi_r != 10'h3ff);
		st_r <= (rst || output_load_strobe_n) ? 10'h000
			: st_r + 10'(st_r != 10'h3ff);
	end
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// ==========
	// properties
	a_frame_len_exact: assert property (
		$rose(frame_n) |-> lo_r == 10'(32 * HALF))
		else $error("frame low length wrong");
	a_frame_gap_min: assert property (
		$fell(frame_n) |-> hi_r >= 10'(2 * HALF))
		else $error("frame gap too short");
	a_frame_start_rise: assert property (
		$fell(frame_n) |-> $rose(sclk))
		else $error("frame start off clock rise");
	a_frame_end_rise: assert property (
		$rose(frame_n) |-> $rose(sclk))
		else $error("frame end off clock rise");
	a_data_on_rise: assert property (
		$changed(sdata) |-> $rose(sclk))
		else $error("data moved off clock rise");
	a_sclk_half_period: assert property (
		$rose(sclk) |-> ##HALF !sclk ##HALF sclk)
		else $error("link clock period wrong");
	a_load_in_gap: assert property (
		$fell(output_load_strobe_n) |-> frame_n && $rose(sclk))
		else $error("load strobe fell inside frame");
	a_load_width_min: assert property (
		$rose(output_load_strobe_n) |-> st_r >= 10'(10 * HALF))
		else $error("load strobe too short");
endmodule // dds_link_assertions

// file: verification/dual_dac_serial_load_test.sv
// bench: host and converter ends joined over the link
module dual_dac_serial_load_test
	import dds_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HC = 2;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic rst_dev = 1'b1;
	logic word_valid = 1'b0;
	logic hold_load_low = 1'b1;
	logic fmt = 1'b0;
	logic word_ready;
	logic busy;
	logic [WORD_BITS:0] word_data = '0;
	logic [CODE_BITS-1:0] la, lb, oa, ob;
	wire [47:0] obs = {ob, oa, lb, la};
	int err_total = 0;
	int n_checks = 0;
	dds_link_if lnk ();
	dds_host #(.HALF_CYC(HC), .DEPTH(32)) dds_host_inst (.sys_clk, .rst,
		.word_valid, .word_ready, .word_data, .hold_load_low,
		.busy_r(busy), .lnk(lnk));
	dds_device dds_device_inst (.lnk(lnk), .rst(rst_dev),
		.code_format_select(fmt), .latch_a_r(la), .latch_b_r(lb),
		.out_a_r(oa), .out_b_r(ob));
	dds_link_assertions #(.HALF(HC)) dds_link_assertions_inst (.sys_clk,
		.rst, .sclk(lnk.sclk), .sdata(lnk.sdata), .frame_n(lnk.frame_n),
		.output_load_strobe_n(lnk.output_load_strobe_n));
	initial forever #10 sys_clk = ~sys_clk;
	// ==========
	// shared tasks
	task conclude;
		if (err_total == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [11:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wait_for(input string nm, input int i, logic [11:0] e);
		int k = 0;
		while (obs[i*12 +: 12] !== e && ++k < 5000)
			@(posedge sys_clk);
		chk(nm, e, obs[i*12 +: 12]);
		if (k == 5000) conclude();
	endtask
	// valid stays up; caller lowers it after the last word
	task automatic push(input logic [16:0] w);
		int k = 0;
		word_data <= w;
		word_valid <= 1'b1;
		do @(posedge sys_clk);
		while (word_ready !== 1'b1 && ++k < 5000);
		if (k == 5000) chk("word_ready", 12'h001, 12'h000);
		if (k == 5000) conclude();
	endtask
	// ==========
	// scenarios
	task auto_update;
		fmt <= 1'b1;
		push(17'h0_e5a3);
		push(17'h0_1123);
		word_valid <= 1'b0;
		wait_for("latch_a", 0, 12'hda3);
		chk("out_a", 12'hda3, oa);
		wait_for("latch_b", 1, 12'h923);
		chk("out_b", 12'h923, ob);
	endtask
	task strobe_load;
		hold_load_low <= 1'b0;
		fmt <= 1'b0;
		push(17'h0_0abc);
		word_valid <= 1'b0;
		wait_for("latch_a", 0, 12'habc);
		chk("out_a", 12'hda3, oa);
		push(17'h1_f456);
		word_valid <= 1'b0;
		wait_for("latch_b", 1, 12'h456);
		chk("out_b", 12'h923, ob);
		wait_for("out_b", 3, 12'h456);
		chk("out_a", 12'habc, oa);
	endtask
	// fills the buffer while the link drains it one frame at a time
	task automatic fill_drain;
		int k = 0;
		logic full = 1'b0;
		hold_load_low <= 1'b1;
		word_data <= '0;
		word_valid <= 1'b1;
		for (int i = 0; i < 200 && !full; i++) begin
			@(posedge sys_clk);
			if (word_ready !== 1'b1)
				full = 1'b1;
			else begin
				k++;
				word_data <= 17'(k);
			end
		end
		word_valid <= 1'b0;
		chk("fifo_full", 12'h001, {11'h000, full});
		chk("busy_r", 12'h001, {11'h000, busy});
		wait_for("out_a", 2, 12'(k - 1));
		for (int i = 0; i < 100 && busy !== 1'b0; i++)
			@(posedge sys_clk);
		chk("busy_r", 12'h000, {11'h000, busy});
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (20) @(posedge sys_clk);
		// a falling link clock in the same step would race the release
		for (int i = 0; i < 8 && lnk.sclk !== 1'b0; i++)
			@(posedge sys_clk);
		chk("sclk", 12'h000, {11'h000, lnk.sclk});
		rst_dev <= 1'b0;
		@(posedge sys_clk);
		auto_update();
		strobe_load();
		fill_drain();
		conclude();
	end
endmodule // dual_dac_serial_load_test

// file: verilog/dds_device.sv
// converter end: serial input register, two input latches, two outputs
module dds_device
	import dds_pkg::*;
(
	dds_link_if.device lnk,
	input wire logic rst,
	input wire logic code_format_select,
	output logic [CODE_BITS-1:0] latch_a_r,
	output logic [CODE_BITS-1:0] latch_b_r,
	output logic [CODE_BITS-1:0] out_a_r,
	output logic [CODE_BITS-1:0] out_b_r
);
	typedef struct packed {
		logic [WORD_BITS-2:0] shreg;
		logic [3:0] cnt;
		logic done;
		logic [2:0] fmt_sync;
		logic fmt_lvl;
		logic [2:0] ld_sync;
		logic ld_lvl;
		logic [CODE_BITS-1:0] latch_a;
		logic [CODE_BITS-1:0] latch_b;
		logic [CODE_BITS-1:0] out_a;
		logic [CODE_BITS-1:0] out_b;
	} dds_dev_st_t;
	dds_dev_st_t s_r, s_nxt;

	always_comb begin
		logic [WORD_BITS-1:0] word;
		logic [CODE_BITS-1:0] lvl;
		word = {s_r.shreg, lnk.sdata};
		lvl = '0;
		s_nxt = s_r;
		// =====================================================
		// pin filters: a level counts once stages two and three agree
		s_nxt.fmt_sync = {s_r.fmt_sync[1:0], code_format_select};
		if (s_r.fmt_sync[1] == s_r.fmt_sync[2]) begin
			s_nxt.fmt_lvl = s_r.fmt_sync[2];
		end
		s_nxt.ld_sync = {s_r.ld_sync[1:0], lnk.output_load_strobe_n};
		if (s_r.ld_sync[1] == s_r.ld_sync[2]) begin
			s_nxt.ld_lvl = s_r.ld_sync[2];
		end
		// =====================================================
		// shift register; bits beyond sixteen in one frame are dropped
		if (lnk.frame_n) begin
			s_nxt.cnt = '0;
			s_nxt.done = 1'b0;
		end else if (!s_r.done) begin
			s_nxt.shreg = word[WORD_BITS-2:0];
			s_nxt.cnt = s_r.cnt + 4'h0001;
			if (s_r.cnt == LAST_BIT_CNT) begin
				s_nxt.done = 1'b1;
				s_nxt.cnt = '0;
				// top three bits never looked at
				lvl = word[CODE_MSB:0];
				if (s_r.fmt_lvl) begin
					lvl = lvl ^ CODE_MSB_MASK;
				end
				if (word[SEL_POS]) begin
					s_nxt.latch_b = lvl;
					if (!s_r.ld_lvl) begin
						s_nxt.out_b = lvl;
					end
				end else begin
					s_nxt.latch_a = lvl;
					if (!s_r.ld_lvl) begin
						s_nxt.out_a = lvl;
					end
				end
			end
		end
		// strobe falling edge: both outputs take their latch codes
		if (s_r.ld_lvl && !s_nxt.ld_lvl) begin
			s_nxt.out_a = s_nxt.latch_a;
			s_nxt.out_b = s_nxt.latch_b;
		end
		if (rst) begin
			s_nxt = '0;
			s_nxt.ld_sync = SYNC_IDLE;
			s_nxt.ld_lvl = 1'b1;
		end
	end

	// link clock is the only clock here
	always_ff @(negedge lnk.sclk) begin
		s_r <= s_nxt;
	end

	assign latch_a_r = s_r.latch_a;
	assign latch_b_r = s_r.latch_b;
	assign out_a_r = s_r.out_a;
	assign out_b_r = s_r.out_b;
endmodule // dds_device

// file: verilog/dds_host.sv
// word fifo and serial host end that drives the converter link
module dds_fifo
	import dds_pkg::*;
#(
	parameter int WIDTH = 17,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
		logic ready;
	} dds_fifo_st_t;
	dds_fifo_st_t s_r, s_nxt;
	logic full, empty;
	assign empty = (s_r.wr == s_r.rd);
	// ready kept in a flop so the push side never sees a raw compare
	assign full = !s_r.ready;
	assign in_ready = s_r.ready;
	assign out_valid = !empty;
	assign out_data = s_r.mem[s_r.rd[AW-1:0]];
	always_comb begin
		s_nxt = s_r;
		if (in_valid && !full) begin
			s_nxt.mem[s_r.wr[AW-1:0]] = in_data;
			s_nxt.wr = s_r.wr + 1'b1;
		end
		if (out_ready && !empty) begin
			s_nxt.rd = s_r.rd + 1'b1;
		end
		if (rst) begin
			s_nxt.wr = '0;
			s_nxt.rd = '0;
		end
		s_nxt.ready = (s_nxt.wr[AW-1:0] != s_nxt.rd[AW-1:0]) ||
			(s_nxt.wr[AW] == s_nxt.rd[AW]);
	end
	always_ff @(posedge sys_clk) begin
		s_r <= s_nxt;
	end
endmodule // dds_fifo

module dds_host
	import dds_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic word_valid,
	output logic word_ready,
	input wire logic [WORD_BITS:0] word_data,
	input wire logic hold_load_low,
	output logic busy_r,
	dds_link_if.host lnk
);
	typedef struct packed {
		logic [7:0] div;
		logic sclk;
		logic frame_n;
		logic sdata;
		logic load_n;
		dds_state_t state;
		logic [4:0] bitn;
		logic [WORD_BITS:0] word;
		logic busy;
	} dds_host_st_t;
	dds_host_st_t s_r, s_nxt;
	logic f_valid, f_ready, wrap, rise;
	logic [WORD_BITS:0] f_data;

	dds_fifo #(.WIDTH(WORD_BITS + 1), .DEPTH(DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(word_valid),
		.in_ready(word_ready),
		.in_data(word_data),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	// =========================================================
	// free running divider; bits change on rising edges only
	assign wrap = (s_r.div == 8'(HALF_CYC - 1));
	assign rise = wrap && !s_r.sclk;
	assign f_ready = rise && (s_r.state == DDS_IDLE);

	always_comb begin
		s_nxt = s_r;
		s_nxt.div = wrap ? 8'h0000 : s_r.div + 8'h0001;
		if (wrap) begin
			s_nxt.sclk = !s_r.sclk;
		end
		if (rise) begin
			unique case (s_r.state)
				DDS_IDLE: begin
					// strobe may only fall while frame select is high
					if (!f_valid || !hold_load_low) begin
						s_nxt.load_n = !hold_load_low;
					end
					if (f_valid) begin
						s_nxt.word = f_data;
						s_nxt.frame_n = 1'b0;
						s_nxt.sdata = f_data[WORD_BITS-1];
						s_nxt.bitn = 5'(WORD_BITS - 1);
						s_nxt.state = DDS_SHIFT;
					end
				end
				DDS_SHIFT: begin
					if (s_r.bitn == 5'h0000) begin
						s_nxt.frame_n = 1'b1;
						s_nxt.state = DDS_GAP;
					end else begin
						s_nxt.bitn = s_r.bitn - 5'h0001;
						s_nxt.sdata = s_r.word[s_r.bitn - 5'h0001];
					end
				end
				DDS_GAP: begin
					if (s_r.word[WORD_BITS] && !hold_load_low) begin
						s_nxt.load_n = 1'b0;
						s_nxt.bitn = LOAD_LOW_PERIODS;
						s_nxt.state = DDS_LOAD;
					end else begin
						s_nxt.load_n = !hold_load_low;
						s_nxt.state = DDS_IDLE;
					end
				end
				DDS_LOAD: begin
					// held several periods so the device filter sees it
					if (s_r.bitn == 5'h0000) begin
						s_nxt.load_n = 1'b1;
						s_nxt.state = DDS_IDLE;
					end else begin
						s_nxt.bitn = s_r.bitn - 5'h0001;
					end
				end
			endcase
		end
		s_nxt.busy = (s_nxt.state != DDS_IDLE) || f_valid;
		if (rst) begin
			s_nxt = '0;
			s_nxt.frame_n = 1'b1;
			s_nxt.load_n = 1'b1;
			s_nxt.state = DDS_IDLE;
		end
	end

	always_ff @(posedge sys_clk) begin
		s_r <= s_nxt;
	end

	assign lnk.sclk = s_r.sclk;
	assign lnk.sdata = s_r.sdata;
	assign lnk.frame_n = s_r.frame_n;
	assign lnk.output_load_strobe_n = s_r.load_n;
	assign busy_r = s_r.busy;
endmodule // dds_host

// file: verilog/dds_link_if.sv
// three-wire serial link plus load strobe between host and converter
interface dds_link_if;
	logic sclk;
	logic sdata;
	logic frame_n;
	logic output_load_strobe_n;
	modport host (
		output sclk,
		output sdata,
		output frame_n,
		output output_load_strobe_n
	);
	modport device (
		input sclk,
		input sdata,
		input frame_n,
		input output_load_strobe_n
	);
endinterface

// file: verilog/dds_pkg.sv
// constants and types shared by both ends of the serial converter link
//
// Notes on behaviour
// - data valid and sampled at falling clock
// - host drops frame select before shifting
// - byte hosts keep frame select low between bytes
// - words go most significant bit first
// - bit twelve zero routes word to A
// - host raises frame select after sixteen bits
// - frame select high gap between two words
// - strobe low: update on sixteenth edge
// - strobe tied low means automatic update
// - strobe falling edge loads both outputs
// - host strobes only after both latches loaded; here it strobes after any word with bit sixteen set
// - top three bits ignored; one picks B
// - format high twos complement, low offset
package dds_pkg;
	// =========================================================
	// word layout
	localparam int WORD_BITS = 16;
	localparam int CODE_BITS = 12;
	localparam int SEL_POS = 12;
	localparam int CODE_MSB = CODE_BITS - 1;
	localparam logic [CODE_BITS-1:0] CODE_MSB_MASK = 12'h0800;
	localparam logic [3:0] LAST_BIT_CNT = 4'h000f;
	// =========================================================
	// host timing, in system clock cycles and link clock periods; device strobe filter idle value
	localparam int SCLK_HALF_CYC = 3;
	localparam logic [4:0] LOAD_LOW_PERIODS = 5'h0004;
	localparam logic [2:0] SYNC_IDLE = 3'h0007;
	// =========================================================
	// host sequencer
	typedef enum logic [1:0] {
		DDS_IDLE,
		DDS_SHIFT,
		DDS_GAP,
		DDS_LOAD
	} dds_state_t;
endpackage
